// ==== rtl/tsp_pkg.sv ====
package tsp_pkg;
   // Fixed upper five bits of the target address
   localparam logic [4:0] ADDR_HIGH = 5'h0f;
   // Low address bits chosen by the strap pin
   localparam logic [1:0] STRAP_FLOAT = 2'h0;
   localparam logic [1:0] STRAP_GND = 2'h1;
   localparam logic [1:0] STRAP_VDD = 2'h2;
   // Strap pin level encodings seen on strap_level_in
   localparam logic [1:0] LVL_FLOAT = 2'h0;
   localparam logic [1:0] LVL_GND = 2'h1;
   localparam logic [1:0] LVL_VDD = 2'h2;
   // Direction bit values
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   // Register that holds the page flag, and the flag position
   localparam logic [7:0] PAGE_REG = 8'h06;
   localparam int PAGE_BIT = 0;
   // Bits per byte on the wire
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Clock figures: system clock and fastest serial clock
   localparam int CLK_HZ = 50_000_000;
   localparam int SCL_MAX_HZ = 400_000;
   // Cycles in one serial clock period at the top rate
   localparam int SCL_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ;
   // Transfer states
   typedef enum logic [5:0] {
      TSP_IDLE = 6'b00_0001,
      TSP_ADDR = 6'b00_0010,
      TSP_ACK = 6'b00_0100,
      TSP_RXB = 6'b00_1000,
      TSP_TXB = 6'b01_0000,
      TSP_MACK = 6'b10_0000
   } tsp_state_t;
endpackage

// ==== rtl/tsp_line_cond.sv ====
`timescale 1ns/1ns
// Samples the bus lines and reports edges and start/stop events
module tsp_line_cond (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_rise_out,
   output logic scl_fall_out,
   output logic sda_level_out,
   output logic start_out,
   output logic stop_out
);
   // Previous samples of each line
   logic scl_q;
   logic sda_q;

   // History registers, bus idles high
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Edge and condition decode
   always_comb begin
      scl_rise_out = scl_in & ~scl_q;
      scl_fall_out = ~scl_in & scl_q;
      sda_level_out = sda_q;
      start_out = scl_in & scl_q & sda_q & ~sda_in;
      stop_out = scl_in & scl_q & ~sda_q & sda_in;
   end
endmodule // tsp_line_cond

// ==== rtl/tsp_target.sv ====
`timescale 1ns/1ns
// Function
// - Answer only address 01111 plus strap bits
// - Eighth bit: zero write, one read
// - Strap float 00, ground 01, supply 10
// - Strap used as sense channel gives 00
// - Serial clock up to 400 kHz supported
// - SDA fall with SCL high starts transfer
// - SDA rise with SCL high ends transfer
// - Address byte sent MSB first, stable
// - Matched address acknowledged by pulling low
// - Register address byte acknowledged and captured
// - Write bytes acknowledged and stored, MSB first
// - Read uses register byte, restart, read address
// - Several bytes per transfer allowed
// - Open drain data sampled while SCL high
// - Page flag at 06h selects register page
module tsp_target (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [1:0] strap_level_in,
   input wire logic strap_is_key_in,
   input wire logic [7:0] reg_rdata_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic [8:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic busy_out
);
   // Line events from the conditioner
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   // Transfer state and bit machinery
   tsp_pkg::tsp_state_t state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic dir_q;
   logic reg_phase_q; // Next written byte is the register address
   logic [7:0] ptr_q;
   logic page_q;
   logic [7:0] tx_q;
   logic [1:0] strap_bits;
   logic [7:0] rx_byte;

   // Low address bits from the strap
   function automatic logic [1:0] strap_decode(input logic [1:0] lvl, input logic is_key);
      logic [1:0] r;
      r = tsp_pkg::STRAP_FLOAT;
      if (is_key) begin
         r = tsp_pkg::STRAP_FLOAT;
      end else if (lvl == tsp_pkg::LVL_GND) begin
         r = tsp_pkg::STRAP_GND;
      end else if (lvl == tsp_pkg::LVL_VDD) begin
         r = tsp_pkg::STRAP_VDD;
      end
      return r;
   endfunction

   // Line conditioner instance
   // Data bits are taken straight from sda_in, so the level output stays open
   tsp_line_cond u_cond (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .sda_level_out(),
      .start_out(start_ev),
      .stop_out(stop_ev)
   );

   // Byte as it will stand after this rising edge
   assign rx_byte = {shift_q[6:0], sda_in};
   assign strap_bits = strap_decode(strap_level_in, strap_is_key_in);

   // Main transfer sequencer, stepped on serial clock edges
   // Edge detection on the fast clock keeps up with any SCL to 400 kHz
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= tsp_pkg::TSP_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         dir_q <= tsp_pkg::DIR_WRITE;
         reg_phase_q <= 1'b0;
      end else if (stop_ev) begin
         state_q <= tsp_pkg::TSP_IDLE;
      end else if (start_ev) begin
         // Start and repeated start both open an address byte
         state_q <= tsp_pkg::TSP_ADDR;
         bit_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            tsp_pkg::TSP_IDLE: begin
               bit_cnt_q <= 4'h0;
            end
            tsp_pkg::TSP_ADDR, tsp_pkg::TSP_RXB: begin
               // Shift in MSB first while SCL is high
               if (scl_rise) begin
                  shift_q <= rx_byte;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == tsp_pkg::BYTE_BITS) begin
                  bit_cnt_q <= 4'h0;
                  if (state_q == tsp_pkg::TSP_RXB) begin
                     state_q <= tsp_pkg::TSP_ACK;
                     reg_phase_q <= 1'b0;
                  end else if (shift_q[7:1] == {tsp_pkg::ADDR_HIGH, strap_bits}) begin
                     state_q <= tsp_pkg::TSP_ACK;
                     dir_q <= shift_q[0];
                     reg_phase_q <= (shift_q[0] == tsp_pkg::DIR_WRITE);
                  end else begin
                     state_q <= tsp_pkg::TSP_IDLE;
                  end
               end
            end
            tsp_pkg::TSP_ACK: begin
               // Acknowledge pulse ends; pick data direction
               if (scl_fall) begin
                  state_q <= (dir_q == tsp_pkg::DIR_READ) ? tsp_pkg::TSP_TXB
                                                          : tsp_pkg::TSP_RXB;
               end
            end
            tsp_pkg::TSP_TXB: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == tsp_pkg::BYTE_BITS) begin
                  bit_cnt_q <= 4'h0;
                  state_q <= tsp_pkg::TSP_MACK;
               end
            end
            tsp_pkg::TSP_MACK: begin
               // Controller acknowledge decides whether another byte follows
               if (scl_rise) begin
                  dir_q <= sda_in;
               end else if (scl_fall) begin
                  state_q <= dir_q ? tsp_pkg::TSP_IDLE : tsp_pkg::TSP_TXB;
                  dir_q <= tsp_pkg::DIR_READ;
               end
            end
         endcase
      end
   end

   // Register pointer, page flag and register strobes
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ptr_q <= 8'h00;
         page_q <= 1'b0;
         reg_wr_out <= 1'b0;
         reg_rd_out <= 1'b0;
         reg_wdata_out <= 8'h00;
         reg_addr_out <= 9'h000;
      end else begin
         reg_wr_out <= 1'b0;
         reg_rd_out <= 1'b0;
         reg_addr_out <= {page_q, ptr_q};
         if (state_q == tsp_pkg::TSP_RXB && scl_fall && bit_cnt_q == tsp_pkg::BYTE_BITS) begin
            if (reg_phase_q) begin
               ptr_q <= shift_q;
            end else begin
               reg_wr_out <= 1'b1;
               reg_wdata_out <= shift_q;
               ptr_q <= ptr_q + 8'h01;
               if (ptr_q == tsp_pkg::PAGE_REG) begin
                  page_q <= shift_q[tsp_pkg::PAGE_BIT];
               end
            end
         end else if (state_q == tsp_pkg::TSP_TXB && scl_fall
                      && bit_cnt_q == tsp_pkg::BYTE_BITS) begin
            ptr_q <= ptr_q + 8'h01;
         end else if (state_q == tsp_pkg::TSP_ACK && scl_rise && dir_q == tsp_pkg::DIR_READ) begin
            reg_rd_out <= 1'b1;
         end else if (state_q == tsp_pkg::TSP_MACK && scl_rise && !sda_in) begin
            reg_rd_out <= 1'b1;
         end
      end
   end

   // Transmit byte, loaded from read data, shifted on falling edges
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_q <= 8'hff;
      end else if (reg_rd_out) begin
         // Page register reads return the local flag on either page
         tx_q <= (ptr_q == tsp_pkg::PAGE_REG) ? {7'h00, page_q} : reg_rdata_in;
      end else if (state_q == tsp_pkg::TSP_TXB && scl_fall) begin
         tx_q <= {tx_q[6:0], 1'b1};
      end
   end

   // Open-drain data drive; only ever pulls low
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         busy_out <= (state_q != tsp_pkg::TSP_IDLE);
         if (start_ev || stop_ev) begin
            sda_oe_out <= 1'b0;
         end else if (state_q == tsp_pkg::TSP_ACK) begin
            sda_oe_out <= 1'b1;
         end else if (state_q == tsp_pkg::TSP_TXB) begin
            sda_oe_out <= ~tx_q[7];
         end else begin
            sda_oe_out <= 1'b0;
         end
      end
   end
endmodule // tsp_target

// ==== verif/tsp_target_asserts.sv ====
`timescale 1ns/1ns
// Watches the target port pins for protocol slips
module tsp_target_asserts (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_out,
   input wire logic [8:0] reg_addr_out,
   input wire logic reg_wr_out,
   input wire logic reg_rd_out,
   input wire logic busy_out
);
   logic [7:0] wr_ptr_q; // Pointer of the last written byte
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Remember where each written byte landed
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_q <= 8'h00;
      end else if (reg_wr_out) begin
         wr_ptr_q <= reg_addr_out[7:0];
      end
   end
   AST_OE_RISE_SCL_LOW: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("data pulled low while clock high");
   AST_OE_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("data drive moved during clock high");
   AST_STOP_IDLE: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !busy_out)
      else $error("no return to idle after stop");
   AST_START_BUSY: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] busy_out)
      else $error("start not taken");
   AST_WR_ONE_CYCLE: assert property (reg_wr_out |=> !reg_wr_out)
      else $error("write strobe too long");
   AST_RD_AT_HIGH: assert property (reg_rd_out |-> scl_in)
      else $error("fetch strobe outside clock high");
   AST_PTR_STEP: assert property (reg_wr_out |=> ##[0:7] reg_addr_out[7:0] == wr_ptr_q + 8'h01)
      else $error("pointer did not step");
   AST_IDLE_QUIET: assert property (!busy_out && !$past(busy_out) |-> !sda_oe_out)
      else $error("data driven while idle");
   // Main traffic seen
   cover property (reg_wr_out);
   cover property (reg_rd_out);
   cover property ($rose(sda_oe_out));
endmodule // tsp_target_asserts

// ==== verif/tsp_host_model.sv ====
`timescale 1ns/1ns
// Bus controller model: makes the clock, pulls data low or releases it
module tsp_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_drv_out
);
   // Bus idles with both lines high
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // Whole system cycles; changes land after falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Start or repeated start: data falls with clock high
   task automatic start();
      sda_drv_out = 1'b1;
      cyc(30);
      scl_out = 1'b1;
      cyc(30);
      sda_drv_out = 1'b0;
      cyc(30);
      scl_out = 1'b0;
      cyc(30);
   endtask
   // Stop: data rises with clock high, then bus free time
   task automatic stop();
      sda_drv_out = 1'b0;
      cyc(30);
      scl_out = 1'b1;
      cyc(30);
      sda_drv_out = 1'b1;
      cyc(70);
   endtask
   // Nine pulses below 400 kHz, MSB first; ninth is the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic ack);
      logic s;
      for (int i = 0; i < 9; i++) begin
         sda_drv_out = (i < 8) ? tx[7 - i] : last;
         cyc(35);
         scl_out = 1'b1;
         cyc(62);
         s = sda_in;
         if (i < 8) begin
            rx = {rx[6:0], s};
         end
         scl_out = 1'b0;
         cyc(30);
      end
      ack = !s;
   endtask
endmodule // tsp_host_model

// ==== verif/tsp_target_tb_top.sv ====
`timescale 1ns/1ns
// Drives the target port through the controller model
module tsp_target_tb_top;
   localparam logic [6:0] DEV = {tsp_pkg::ADDR_HIGH, tsp_pkg::STRAP_FLOAT};
   logic clk_in, reset_n_in, scl, host_sda, sda_oe, key, wr, rd, busy, ack, dut_sda;
   logic [1:0] strap;
   logic [7:0] rdata, wdata, rx;
   logic [8:0] addr;
   logic [7:0] mem [0:511]; // Register file stand-in
   int errors, checks;
   wire logic sda = host_sda & !sda_oe; // Open-drain wire with pull-up
   tsp_host_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_drv_out(host_sda));
   tsp_target dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
      .strap_level_in(strap), .strap_is_key_in(key), .reg_rdata_in(rdata), .sda_out(dut_sda),
      .sda_oe_out(sda_oe), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
      .reg_rd_out(rd), .busy_out(busy));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = !clk_in;
   end
   // Stores written bytes, fetches on the read strobe
   always @(negedge clk_in) begin
      if (wr) mem[addr] <= wdata;
      if (rd) rdata <= mem[addr];
   end
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Bounded wait for the port to go idle
   task automatic wait_idle();
      for (int i = 0; i < 20 && busy; i++) @(negedge clk_in);
      chk(busy, 0);
      if (busy) complete_run();
   endtask
   // Write-direction address then register byte
   task automatic open_at(input logic [7:0] ptr);
      host.start();
      host.byte_io({DEV, tsp_pkg::DIR_WRITE}, 1'b1, rx, ack);
      chk(ack, 1);
      host.byte_io(ptr, 1'b1, rx, ack);
      chk(ack, 1);
   endtask
   // Every strap setting: own address taken, neighbour refused
   task automatic t_strap();
      logic [1:0] lo;
      for (int k = 0; k < 8; k++) begin
         strap = k[1:0];
         key = k[2];
         lo = (key || strap == 2'h3) ? 2'h0 : strap;
         host.start();
         host.byte_io({tsp_pkg::ADDR_HIGH, lo ^ 2'h1, 1'b0}, 1'b1, rx, ack);
         chk(ack, 0);
         host.stop();
         host.start();
         host.byte_io({tsp_pkg::ADDR_HIGH, lo, 1'b0}, 1'b1, rx, ack);
         chk(ack, 1);
         host.stop();
         wait_idle();
      end
      strap = 2'h0;
      key = 1'b0;
   endtask
   // Two bytes in one write, then read back with restart
   task automatic t_wr_rd();
      open_at(8'h10);
      for (int i = 0; i < 2; i++) begin
         host.byte_io(i ? 8'hc3 : 8'h3c, 1'b1, rx, ack);
         chk(ack, 1);
      end
      host.stop();
      wait_idle();
      chk(mem[9'h011], 8'hc3);
      open_at(8'h10);
      host.start();
      host.byte_io({DEV, tsp_pkg::DIR_READ}, 1'b1, rx, ack);
      chk(ack, 1);
      host.byte_io(8'hff, 1'b0, rx, ack);
      chk(rx, 8'h3c);
      host.byte_io(8'hff, 1'b1, rx, ack);
      chk(rx, 8'hc3);
      host.stop();
      wait_idle();
   endtask
   // Upper page write, abort after register byte, page back
   task automatic t_page();
      open_at(8'h06);
      host.byte_io(8'h01, 1'b1, rx, ack);
      host.stop();
      open_at(8'h06);
      host.start();
      host.byte_io({DEV, tsp_pkg::DIR_READ}, 1'b1, rx, ack);
      host.byte_io(8'hff, 1'b1, rx, ack);
      chk(rx, 8'h01);
      host.stop();
      open_at(8'h20);
      host.byte_io(8'h5a, 1'b1, rx, ack);
      host.stop();
      chk(mem[9'h120], 8'h5a);
      open_at(8'h30);
      host.stop();
      wait_idle();
      chk(addr, 9'h130);
      open_at(8'h06);
      host.byte_io(8'h00, 1'b1, rx, ack);
      host.stop();
      chk(addr[8], 0);
   endtask
   // Reset in mid-run clears pointer, page and every drive
   task automatic t_reset();
      open_at(8'h06);
      host.byte_io(8'h01, 1'b1, rx, ack);
      host.stop();
      chk(addr, 9'h107);
      reset_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      chk({4'h0, busy, sda_oe, dut_sda, wr, rd}, 9'h000);
      chk(addr, 9'h000);
      reset_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      open_at(8'h40);
      host.stop();
      wait_idle();
      chk(addr, 9'h040);
   endtask
   initial begin
      reset_n_in = 1'b0;
      strap = 2'h0;
      key = 1'b0;
      rdata = 8'h00;
      errors = 0;
      checks = 0;
      repeat (5) @(negedge clk_in);
      reset_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      t_strap();
      t_wr_rd();
      t_page();
      t_reset();
      complete_run();
   end
   // Hang guard
   initial begin
      #2_000_000;
      errors++;
      complete_run();
   end
endmodule // tsp_target_tb_top
bind tsp_target tsp_target_asserts chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_oe_out(sda_oe_out), .reg_addr_out(reg_addr_out),
   .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .busy_out(busy_out));
